// ===== shared/pef_pkg.sv
// Shared constants and types for the port event flag block
package pef_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the two-wire bus)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SUMMARY = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h01;
    localparam logic [7:0] ADDR_PWR_FLAGS = 8'h02;
    localparam logic [7:0] ADDR_PWR_FLAGS_COR = 8'h03;
    localparam logic [7:0] ADDR_PROBE_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_PROBE_FLAGS_COR = 8'h05;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h80;
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PORTS = 4;
    localparam int PGOOD_LSB = 4;      // Flag bits 7:4, ports 4..1
    localparam int PEN_LSB = 0;        // Flag bits 3:0, ports 4..1
    localparam int CLASS_LSB = 4;
    localparam int DETECT_LSB = 0;
    localparam int SUM_PEN_BIT = 0;
    localparam int SUM_PGOOD_BIT = 1;
    localparam int SUM_DETECT_BIT = 3;
    localparam int SUM_CLASS_BIT = 4;

    // ------------------------------------------------------------
    // Serial link constants
    // ------------------------------------------------------------
    // Device bus address: arbitrary value
    localparam logic [6:0] DEV_ADDR = 7'h20;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic SDA_LOW_LEVEL = 1'b0;

    // ------------------------------------------------------------
    // Probe result encodings
    // ------------------------------------------------------------
    localparam int SIG_W = 3;
    localparam int CLS_W = 4;
    localparam logic [SIG_W-1:0] VALID_SIGNATURE = 3'h4;
    localparam logic [SIG_W-1:0] SIG_RESET = 3'h0;
    localparam logic [CLS_W-1:0] CLS_RESET = 4'h0;

    typedef struct packed {
        logic [PORTS-1:0] detect_update;
        logic [PORTS-1:0] class_update;
        logic [PORTS-1:0][SIG_W-1:0] port_signature_result;
        logic [PORTS-1:0][CLS_W-1:0] port_classify_result;
    } pef_probe_in_t;

    typedef struct packed {
        logic [SIG_W-1:0] signature;
        logic [CLS_W-1:0] classify;
    } pef_probe_status_t;

    typedef enum logic [2:0] {
        LS_IDLE = 3'b000,
        LS_ADDR = 3'b001,
        LS_ACK_A = 3'b011,
        LS_WRITE = 3'b010,
        LS_ACK_W = 3'b110,
        LS_READ = 3'b111,
        LS_RACK = 3'b101,
        LS_SKIP = 3'b100
    } pef_link_state_t;

endpackage : pef_pkg

// ===== hdl/pef_flag_bank.sv
// Eight sticky event flags with set-over-clear
`timescale 1ns/1ps
`default_nettype none
module pef_flag_bank
    import pef_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] set,
    input wire logic [7:0] clr,
    output logic [7:0] flags
);
    wire logic [7:0] next_flags;

    // A set in the clearing cycle survives
    assign next_flags = set | (flags & ~clr);

    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end
endmodule : pef_flag_bank
`default_nettype wire

// ===== hdl/pef_link_capture.sv
// Serial clock domain: samples the data line on each rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pef_link_capture
    import pef_pkg::*;
(
    input wire logic scl,
    input wire logic rst,
    input wire logic sda_in,
    output logic bit_val,
    output logic bit_toggle
);
    // Loaded straight from reset, bit copy high and toggle low, as the bus clock idles then
    // A release on a clock edge gives one stray event, ignored when idle
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            bit_val <= 1'b1;
            bit_toggle <= 1'b0;
        end else begin
            bit_val <= sda_in;
            bit_toggle <= ~bit_toggle;
        end
    end
endmodule : pef_link_capture
`default_nettype wire

// ===== hdl/pef_port_event_flags.sv
// Per-quad event flags, summary roll-up and interrupt pin with serial register access
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Reading a clear-on-read flag view clears the related summary bits.
// - Setting a port to shutdown clears the summary bits.
// - Push-button off, quad reset, port reset, clear-all, emergency stop clear summaries.
// - Pin release deasserts the interrupt output, leaving every flag untouched.
// - Power flags at 0x02 plain view and 0x03 clear-on-read; both reset zero.
// - Power flag bits 7:4 mark power-good change of ports 4..1.
// - Power flag bits 3:0 mark power-enable change of ports 4..1.
// - Any power-good change flag sets the power-good summary bit.
// - Any power-enable change flag sets the power-enable summary bit.
// - Probe flags at 0x04 plain view and 0x05 clear-on-read; both reset zero.
// - Probe flag bits 7:4 mark classification updated for ports 4..1.
// - Probe flag bits 3:0 mark detection updated for ports 4..1, whatever the signature result when detect-on-change is off.
// - Any detection-done flag sets the detection summary bit.
// - With detect-on-change, detection flag rises only when the result differs.
// - Any classification-done flag sets the classification summary bit.
// - A reported classification comes with a valid signature status, until a later detection alone overwrites the signature.
// - Interrupt pin low when summary AND mask is nonzero.
module pef_port_event_flags
    import pef_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    input wire logic [PORTS-1:0] PORT_PGOOD_STATE,
    input wire logic [PORTS-1:0] PORT_PEN_STATE,
    input wire pef_probe_in_t PROBE_IN,
    input wire logic DETECT_ON_CHANGE,
    input wire logic [PORTS-1:0] PORT_SHUTDOWN_SET,
    input wire logic [PORTS-1:0] PUSH_BUTTON_POWER_OFF,
    input wire logic QUAD_RESET,
    input wire logic [PORTS-1:0] PORT_RESET_CMD,
    input wire logic CLEAR_EVERY_SUMMARY,
    input wire logic EMERGENCY_STOP,
    input wire logic IRQ_PIN_RELEASE,
    output pef_probe_status_t [PORTS-1:0] PORT_PROBE_STATUS,
    output logic IRQ_OUT_N
);
    // ------------------------------------------------------------
    // Serial line synchronisers and bit capture
    // ------------------------------------------------------------
    logic scl_s1, scl_s2, scl_prev;
    logic sda_s1, sda_s2, sda_prev;
    logic tgl_s1, tgl_s2, tgl_s3, tgl_s4;
    logic bitv_s1, bitv_s2;
    wire logic cap_bit;
    wire logic cap_toggle;

    pef_link_capture u_capture (
        .scl(SCL),
        .rst(RESET),
        .sda_in(SDA_I),
        .bit_val(cap_bit),
        .bit_toggle(cap_toggle)
    );

    always_ff @(posedge CLK) begin
        scl_s1 <= SCL;
        scl_s2 <= scl_s1;
        scl_prev <= scl_s2;
        sda_s1 <= SDA_I;
        sda_s2 <= sda_s1;
        sda_prev <= sda_s2;
        tgl_s1 <= cap_toggle;
        tgl_s2 <= tgl_s1;
        tgl_s3 <= tgl_s2;
        tgl_s4 <= tgl_s3;
        bitv_s1 <= cap_bit;
        bitv_s2 <= bitv_s1;
    end

    wire logic start_det = scl_s2 & scl_prev & sda_prev & ~sda_s2;
    wire logic stop_det = scl_s2 & scl_prev & ~sda_prev & sda_s2;
    wire logic scl_fall = scl_prev & ~scl_s2;
    // Edge seen one cycle late so the bit copy has settled
    wire logic bit_evt = tgl_s3 ^ tgl_s4;
    wire logic rx_bit = bitv_s2;

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic [PORTS-1:0] pgood_prev;
    logic [PORTS-1:0] pen_prev;
    logic [PORTS-1:0][SIG_W-1:0] sig_prev;
    wire logic [PORTS-1:0] pgood_evt = PORT_PGOOD_STATE ^ pgood_prev;
    wire logic [PORTS-1:0] pen_evt = PORT_PEN_STATE ^ pen_prev;
    logic [PORTS-1:0] det_evt;

    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp++) begin : g_port
            wire logic sig_diff = PROBE_IN.port_signature_result[gp] != sig_prev[gp];
            assign det_evt[gp] = PROBE_IN.detect_update[gp] & (~DETECT_ON_CHANGE | sig_diff);

            always_ff @(posedge CLK) begin
                if (RESET) begin
                    sig_prev[gp] <= SIG_RESET;
                    PORT_PROBE_STATUS[gp] <= {SIG_RESET, CLS_RESET};
                end else if (PROBE_IN.class_update[gp]) begin
                    sig_prev[gp] <= PROBE_IN.detect_update[gp] ?
                        PROBE_IN.port_signature_result[gp] : sig_prev[gp];
                    PORT_PROBE_STATUS[gp].signature <= VALID_SIGNATURE;
                    PORT_PROBE_STATUS[gp].classify <= PROBE_IN.port_classify_result[gp];
                end else if (PROBE_IN.detect_update[gp]) begin
                    sig_prev[gp] <= PROBE_IN.port_signature_result[gp];
                    PORT_PROBE_STATUS[gp].signature <= PROBE_IN.port_signature_result[gp];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pgood_prev <= '0;
            pen_prev <= '0;
        end else begin
            pgood_prev <= PORT_PGOOD_STATE;
            pen_prev <= PORT_PEN_STATE;
        end
    end

    // ------------------------------------------------------------
    // Flag banks
    // ------------------------------------------------------------
    logic cor_pwr;
    logic cor_probe;
    wire logic [7:0] pwr_flags;
    wire logic [7:0] probe_flags;
    wire logic [7:0] pwr_set = {pgood_evt, pen_evt};
    wire logic [7:0] probe_set = {PROBE_IN.class_update, det_evt};
    wire logic [7:0] port_clr = {PORT_RESET_CMD, PORT_RESET_CMD};
    wire logic [7:0] quad_clr = {8{QUAD_RESET}};
    wire logic [7:0] pwr_clr = {8{cor_pwr}} | port_clr | quad_clr;
    wire logic [7:0] probe_clr = {8{cor_probe}} | port_clr | quad_clr;

    pef_flag_bank u_pwr_bank (
        .clk(CLK),
        .rst(RESET),
        .set(pwr_set),
        .clr(pwr_clr),
        .flags(pwr_flags)
    );

    pef_flag_bank u_probe_bank (
        .clk(CLK),
        .rst(RESET),
        .set(probe_set),
        .clr(probe_clr),
        .flags(probe_flags)
    );

    // ------------------------------------------------------------
    // Summary bits and interrupt pin
    // ------------------------------------------------------------
    logic [7:0] summary;
    logic [7:0] mask;
    logic pin_released;
    wire logic clr_common = CLEAR_EVERY_SUMMARY | EMERGENCY_STOP | QUAD_RESET
        | (|PORT_SHUTDOWN_SET) | (|PUSH_BUTTON_POWER_OFF) | (|PORT_RESET_CMD);
    wire logic clr_pwr_sum = clr_common | cor_pwr;
    wire logic clr_probe_sum = clr_common | cor_probe;
    wire logic [7:0] sum_evt;
    wire logic [7:0] sum_keep;
    wire logic [7:0] next_summary;

    assign sum_evt = {3'b000, |probe_set[CLASS_LSB +: PORTS], |probe_set[DETECT_LSB +: PORTS],
        1'b0, |pwr_set[PGOOD_LSB +: PORTS], |pwr_set[PEN_LSB +: PORTS]};
    assign sum_keep = {3'b000,
        ~clr_probe_sum & (|probe_flags[CLASS_LSB +: PORTS]),
        ~clr_probe_sum & (|probe_flags[DETECT_LSB +: PORTS]),
        1'b0,
        ~clr_pwr_sum & (|pwr_flags[PGOOD_LSB +: PORTS]),
        ~clr_pwr_sum & (|pwr_flags[PEN_LSB +: PORTS])};
    assign next_summary = sum_evt | (summary & sum_keep);

    wire logic quad_int = |(summary & mask);
    wire logic new_int = |(sum_evt & ~summary & mask);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            summary <= SUMMARY_RESET;
            pin_released <= 1'b0;
            IRQ_OUT_N <= 1'b1;
        end else begin
            summary <= next_summary;
            pin_released <= new_int ? 1'b0 : (pin_released | IRQ_PIN_RELEASE);
            IRQ_OUT_N <= ~(quad_int & ~pin_released & ~IRQ_PIN_RELEASE);
        end
    end

    // ------------------------------------------------------------
    // Register read selection
    // ------------------------------------------------------------
    logic [7:0] ptr;
    wire logic [7:0] rd_data;
    wire logic rd_is_pwr = (ptr == ADDR_PWR_FLAGS) | (ptr == ADDR_PWR_FLAGS_COR);
    wire logic rd_is_probe = (ptr == ADDR_PROBE_FLAGS) | (ptr == ADDR_PROBE_FLAGS_COR);

    assign rd_data = (ptr == ADDR_SUMMARY) ? summary :
        (ptr == ADDR_MASK) ? mask :
        rd_is_pwr ? pwr_flags :
        rd_is_probe ? probe_flags : 8'h00;

    // ------------------------------------------------------------
    // Two-wire slave protocol engine
    // ------------------------------------------------------------
    pef_link_state_t state;
    pef_link_state_t next_state;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic is_read;
    logic ptr_pending;
    logic sda_drive;
    wire logic [7:0] rx_byte = {rx_shift[6:0], rx_bit};
    wire logic last_bit = bit_cnt == BIT_LAST;
    wire logic addr_hit = rx_byte[7:1] == DEV_ADDR;
    wire logic load_tx = bit_evt & (((state == LS_ACK_A) & is_read)
        | ((state == LS_RACK) & ~rx_bit));
    wire logic wr_byte = bit_evt & (state == LS_WRITE) & last_bit & ~ptr_pending;

    always_comb begin
        next_state = state;
        if (bit_evt) begin
            case (state)
                LS_ADDR: next_state = last_bit ? (addr_hit ? LS_ACK_A : LS_SKIP) : LS_ADDR;
                LS_ACK_A: next_state = is_read ? LS_READ : LS_WRITE;
                LS_WRITE: next_state = last_bit ? LS_ACK_W : LS_WRITE;
                LS_ACK_W: next_state = LS_WRITE;
                LS_READ: next_state = last_bit ? LS_RACK : LS_READ;
                LS_RACK: next_state = rx_bit ? LS_SKIP : LS_READ;
                default: next_state = state;
            endcase
        end
        if (start_det) begin
            next_state = LS_ADDR;
        end else if (stop_det) begin
            next_state = LS_IDLE;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= LS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            bit_cnt <= BIT_FIRST;
            rx_shift <= 8'h00;
        end else if (start_det | (bit_evt & (last_bit | (state == LS_ACK_A)
            | (state == LS_ACK_W) | (state == LS_RACK)))) begin
            bit_cnt <= BIT_FIRST;
            rx_shift <= 8'h00;
        end else if (bit_evt) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_shift <= rx_byte;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            is_read <= 1'b0;
            ptr_pending <= 1'b0;
            ptr <= PTR_RESET;
            mask <= MASK_RESET;
            tx_shift <= 8'h00;
        end else begin
            if (bit_evt & (state == LS_ADDR) & last_bit) begin
                is_read <= rx_bit;
                ptr_pending <= ~rx_bit;
            end
            if (bit_evt & (state == LS_WRITE) & last_bit & ptr_pending) begin
                ptr <= rx_byte;
                ptr_pending <= 1'b0;
            end else if (wr_byte | load_tx) begin
                ptr <= ptr + 8'h01;
            end
            if (wr_byte & (ptr == ADDR_MASK)) begin
                mask <= rx_byte;
            end
            if (load_tx) begin
                tx_shift <= rd_data;
            end else if (bit_evt & (state == LS_READ)) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    // Clear-on-read strobes fire as the byte is loaded for sending
    always_comb begin
        cor_pwr = load_tx & (ptr == ADDR_PWR_FLAGS_COR);
        cor_probe = load_tx & (ptr == ADDR_PROBE_FLAGS_COR);
    end

    // Data line only changes after a falling clock edge, or is released on a start or stop
    always_ff @(posedge CLK) begin
        if (RESET | start_det | stop_det) begin
            sda_drive <= 1'b0;
        end else if (scl_fall) begin
            case (state)
                LS_ACK_A: sda_drive <= 1'b1;
                LS_ACK_W: sda_drive <= 1'b1;
                LS_READ: sda_drive <= ~tx_shift[7];
                default: sda_drive <= 1'b0;
            endcase
        end
    end

    assign SDA_O = SDA_LOW_LEVEL;
    assign SDA_OE_N = ~sda_drive;
endmodule : pef_port_event_flags
`default_nettype wire

// ===== testbench/pef_checker.sv
// Port-level assertions for the port event flag block
`timescale 1ns/1ps
`default_nettype none
module pef_checker
    import pef_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SCL,
    input wire logic SDA_OE_N,
    input wire logic [PORTS-1:0] PORT_PGOOD_STATE,
    input wire logic [PORTS-1:0] PORT_PEN_STATE,
    input wire pef_probe_in_t PROBE_IN,
    input wire logic [PORTS-1:0] PORT_SHUTDOWN_SET,
    input wire logic [PORTS-1:0] PUSH_BUTTON_POWER_OFF,
    input wire logic QUAD_RESET,
    input wire logic [PORTS-1:0] PORT_RESET_CMD,
    input wire logic CLEAR_EVERY_SUMMARY,
    input wire logic EMERGENCY_STOP,
    input wire logic IRQ_PIN_RELEASE,
    input wire pef_probe_status_t [PORTS-1:0] PORT_PROBE_STATUS,
    input wire logic IRQ_OUT_N
);
    // ----
    // Helpers
    // ----
    logic [PORTS-1:0] pg_q;
    logic [PORTS-1:0] pe_q;
    logic [4:0] idle_cnt;
    wire logic evt = (pg_q != PORT_PGOOD_STATE) || (pe_q != PORT_PEN_STATE)
        || (|PROBE_IN.detect_update) || (|PROBE_IN.class_update);
    wire logic clr_any = (|PORT_SHUTDOWN_SET) || (|PUSH_BUTTON_POWER_OFF) || QUAD_RESET
        || (|PORT_RESET_CMD) || CLEAR_EVERY_SUMMARY || EMERGENCY_STOP;
    // Bus quiet long enough that no register access is in flight
    wire logic idle = (idle_cnt >= 5'h10);

    always_ff @(posedge CLK) begin
        pg_q <= PORT_PGOOD_STATE;
        pe_q <= PORT_PEN_STATE;
        idle_cnt <= (RESET || !SCL) ? 5'h00 : idle_cnt + 5'(idle_cnt != 5'h1f);
    end

    // ----
    // Assertions
    // ----
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    rel_high_a: assert property (IRQ_PIN_RELEASE |=> IRQ_OUT_N)
        else $error("irq pin not released");
    rel_hold_a: assert property (!evt ##1 IRQ_PIN_RELEASE && !evt ##1 !evt [*4]
        |=> IRQ_OUT_N) else $error("irq pin fell without event");
    clr_sum_a: assert property (clr_any && !evt ##1 !evt |=> IRQ_OUT_N)
        else $error("summary not cleared");
    rst_val_a: assert property ($fell(RESET) |-> IRQ_OUT_N && SDA_OE_N
        && PORT_PROBE_STATUS == '0) else $error("bad reset state");
    sda_hold_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE_N))
        else $error("data line moved with clock high");
    irq_fall_a: assert property ($fell(IRQ_OUT_N) && idle |-> $past(evt, 2))
        else $error("irq fell without event");
    irq_rise_a: assert property ($rose(IRQ_OUT_N) && idle
        |-> $past(IRQ_PIN_RELEASE) || $past(clr_any, 2)) else $error("irq rose alone");
    for (genvar i = 0; i < PORTS; i++) begin : g_port
        cls_stat_a: assert property (PROBE_IN.class_update[i] |=>
            PORT_PROBE_STATUS[i] == {VALID_SIGNATURE, $past(PROBE_IN.port_classify_result[i])})
            else $error("class status wrong");
        det_stat_a: assert property (PROBE_IN.detect_update[i] && !PROBE_IN.class_update[i]
            |=> PORT_PROBE_STATUS[i].signature == $past(PROBE_IN.port_signature_result[i]))
            else $error("signature status wrong");
    end

    cover property ($fell(IRQ_OUT_N));
    cover property ($fell(SDA_OE_N));
    cover property (clr_any ##2 $rose(IRQ_OUT_N));
endmodule : pef_checker

bind pef_port_event_flags pef_checker i_pef_checker (.CLK, .RESET, .SCL, .SDA_OE_N,
    .PORT_PGOOD_STATE, .PORT_PEN_STATE, .PROBE_IN, .PORT_SHUTDOWN_SET,
    .PUSH_BUTTON_POWER_OFF, .QUAD_RESET, .PORT_RESET_CMD, .CLEAR_EVERY_SUMMARY,
    .EMERGENCY_STOP, .IRQ_PIN_RELEASE, .PORT_PROBE_STATUS, .IRQ_OUT_N);
`default_nettype wire

// ===== testbench/pef_host_model.sv
// Two-wire bus host that reaches the flag registers
`timescale 1ns/1ps
`default_nettype none
module pef_host_model
    import pef_pkg::*;
(
    output logic scl,
    output wire logic sda,
    input wire logic sda_oe_n
);
    logic pull = 1'b0;
    int nak_count = 0;
    // Pulled-up open-drain line
    assign sda = !(pull || !sda_oe_n);
    initial scl = 1'b1;

    // ----
    // Bus tasks
    // ----
    task automatic bit_io(input logic b, output logic r);
        #40 pull = !b;
        #40 scl = 1'b1;
        r = sda;
        #80 scl = 1'b0;
    endtask : bit_io

    task automatic start;
        #40 pull = 1'b0;
        #40 scl = 1'b1;
        #40 pull = 1'b1;
        #40 scl = 1'b0;
    endtask : start

    task automatic stop;
        #40 pull = 1'b1;
        #40 scl = 1'b1;
        #40 pull = 1'b0;
        #80;
    endtask : stop

    task automatic send(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        if (r)
            nak_count++;
    endtask : send

    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic r;
        #3.7 start();
        send({DEV_ADDR, 1'b0});
        send(ptr);
        start();
        send({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop();
    endtask : rd

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        #3.7 start();
        send({DEV_ADDR, 1'b0});
        send(ptr);
        send(d);
        stop();
    endtask : wr
endmodule : pef_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the port event flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pef_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic [PORTS-1:0] pgood = '0, pen = '0, shut = '0, pboff = '0, prst = '0;
    logic qrst = 1'b0, clr_all = 1'b0, estop = 1'b0, rel_irq = 1'b0, doc = 1'b0;
    pef_probe_in_t probe = '0;
    pef_probe_status_t [PORTS-1:0] status;
    logic irq_n, oe_n;
    wire logic scl, sda;
    int num_errors = 0;
    int check_count = 0;

    pef_port_event_flags i_pef_port_event_flags (.CLK(clk), .RESET(rst), .SCL(scl),
        .SDA_I(sda), .SDA_O(), .SDA_OE_N(oe_n), .PORT_PGOOD_STATE(pgood),
        .PORT_PEN_STATE(pen), .PROBE_IN(probe), .DETECT_ON_CHANGE(doc),
        .PORT_SHUTDOWN_SET(shut), .PUSH_BUTTON_POWER_OFF(pboff), .QUAD_RESET(qrst),
        .PORT_RESET_CMD(prst), .CLEAR_EVERY_SUMMARY(clr_all), .EMERGENCY_STOP(estop),
        .IRQ_PIN_RELEASE(rel_irq), .PORT_PROBE_STATUS(status), .IRQ_OUT_N(irq_n));
    pef_host_model i_pef_host_model (.scl(scl), .sda(sda), .sda_oe_n(oe_n));

    initial begin
        forever #4 clk = !clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_pef_host_model.rd(a, d);
        tick(2);
        check($sformatf("reg %h", a), d, exp);
    endtask : rd_chk

    task automatic pulse_probe(input logic [3:0] det, input logic [3:0] cls);
        probe.detect_update = det;
        probe.class_update = cls;
        tick(1);
        probe.detect_update = '0;
        probe.class_update = '0;
        tick(3);
    endtask : pulse_probe

    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rd_chk(ADDR_PWR_FLAGS, 8'h00);
        rd_chk(ADDR_PWR_FLAGS_COR, 8'h00);
        rd_chk(ADDR_PROBE_FLAGS, 8'h00);
        rd_chk(ADDR_PROBE_FLAGS_COR, 8'h00);
        rd_chk(ADDR_MASK, 8'h80);
        rd_chk(8'h06, 8'h00);
        i_pef_host_model.start();
        i_pef_host_model.send({DEV_ADDR ^ 7'h01, 1'b0});
        i_pef_host_model.stop();
        tick(2);
        check("foreign address", 8'(i_pef_host_model.nak_count), 8'h01);
        $display("test reset done");
    endtask : t_reset

    task automatic t_power;
        pgood[3] = 1'b1;
        pen[0] = 1'b1;
        tick(4);
        check("irq masked", 8'(irq_n), 8'h01);
        rd_chk(ADDR_SUMMARY, 8'h03);
        i_pef_host_model.wr(ADDR_MASK, 8'hff);
        tick(4);
        check("irq", 8'(irq_n), 8'h00);
        rd_chk(ADDR_PWR_FLAGS, 8'h81);
        rd_chk(ADDR_PWR_FLAGS_COR, 8'h81);
        rd_chk(ADDR_PWR_FLAGS, 8'h00);
        rd_chk(ADDR_SUMMARY, 8'h00);
        check("irq", 8'(irq_n), 8'h01);
        $display("test power done");
    endtask : t_power

    task automatic t_probe;
        probe.port_classify_result[1] = 4'h3;
        probe.port_signature_result[2] = VALID_SIGNATURE;
        pulse_probe(4'h4, 4'h2);
        check("status", 8'(status[1]), 8'({VALID_SIGNATURE, 4'h3}));
        rd_chk(ADDR_PROBE_FLAGS, 8'h24);
        rd_chk(ADDR_SUMMARY, 8'h18);
        rd_chk(ADDR_PROBE_FLAGS_COR, 8'h24);
        rd_chk(ADDR_PROBE_FLAGS, 8'h00);
        doc = 1'b1;
        pulse_probe(4'h4, 4'h0);
        rd_chk(ADDR_PROBE_FLAGS, 8'h00);
        probe.port_signature_result[2] = SIG_RESET;
        pulse_probe(4'h4, 4'h0);
        rd_chk(ADDR_PROBE_FLAGS_COR, 8'h04);
        doc = 1'b0;
        $display("test probe done");
    endtask : t_probe

    task automatic t_clear;
        for (int k = 0; k < 6; k++) begin
            pen[1] = !pen[1];
            tick(4);
            check("irq set", 8'(irq_n), 8'h00);
            case (k)
                0: shut = 4'h2;
                1: pboff = 4'h2;
                2: qrst = 1'b1;
                3: prst = 4'h2;
                4: clr_all = 1'b1;
                default: estop = 1'b1;
            endcase
            tick(1);
            {shut, pboff, prst, qrst, clr_all, estop} = '0;
            tick(3);
            check("irq clr", 8'(irq_n), 8'h01);
            rd_chk(ADDR_SUMMARY, 8'h00);
            rd_chk(ADDR_PWR_FLAGS_COR, (k == 2 || k == 3) ? 8'h00 : 8'h02);
        end
        $display("test clear done");
    endtask : t_clear

    task automatic t_release;
        pgood[0] = 1'b1;
        tick(4);
        check("irq set", 8'(irq_n), 8'h00);
        rel_irq = 1'b1;
        tick(1);
        rel_irq = 1'b0;
        tick(6);
        check("irq rel", 8'(irq_n), 8'h01);
        rd_chk(ADDR_SUMMARY, 8'h02);
        rd_chk(ADDR_PWR_FLAGS_COR, 8'h10);
        $display("test release done");
    endtask : t_release

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #1;
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(3);
        t_reset();
        t_power();
        t_probe();
        t_clear();
        t_release();
        tally_and_finish();
    end

    initial begin
        #400_000;
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
